// ==== include/gcicf_regs.svh ====
/*
   Register offsets, field positions, reset values and timing counts of the
   channel configuration and command/indicate transmit port.
   Assumes a 20 MHz system clock and byte addresses on the processor port.
*/
`ifndef GCICF_REGS_SVH
`define GCICF_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define GCICF_ADDR_DEF0 8'h22
`define GCICF_ADDR_DEF1 8'h24
`define GCICF_ADDR_DEF2 8'h26
`define GCICF_ADDR_DEF3 8'h28
`define GCICF_ADDR_PRIMITIVE_TX_COMMAND 8'h2A

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define GCICF_DEF_RESET 16'h0000
`define GCICF_PRIMITIVE_TX_COMMAND_RESET 16'h00FF
`define GCICF_PRIM_RESET 6'h3F
`define GCICF_COUNT_RESET 2'h3
`define GCICF_MEM_PRIM_RESET 6'h3F

// ----------------------------------------------------------------
// Transmit command register fields
// ----------------------------------------------------------------
`define GCICF_PRIMITIVE_TX_COMMAND_MUX_BIT 14
`define GCICF_PRIMITIVE_TX_COMMAND_CA_HI 13
`define GCICF_PRIMITIVE_TX_COMMAND_CA_LO 11
`define GCICF_PRIMITIVE_TX_COMMAND_READ_BIT 10
`define GCICF_PRIMITIVE_TX_COMMAND_PT_HI 7
`define GCICF_PRIMITIVE_TX_COMMAND_PT_LO 6
`define GCICF_PRIMITIVE_TX_COMMAND_PRIM_HI 5
`define GCICF_PRIMITIVE_TX_COMMAND_PRIM_LO 0

// ----------------------------------------------------------------
// Primitive shift order
// ----------------------------------------------------------------
`define GCICF_FIRST_BIT_6 3'h5
`define GCICF_FIRST_BIT_4 3'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define GCICF_HOLD_MS 125
`define GCICF_CLK_KHZ 20000
`define GCICF_HOLD_CYCLES (`GCICF_HOLD_MS * `GCICF_CLK_KHZ)

`endif

// ==== include/gcicf_pkg.sv ====
/*
   Types shared by the channel configuration port and its helpers.
   Assumes the offsets and counts of gcicf_regs.svh.
*/
package gcicf_pkg;

   // One nibble of a definition register, most significant bit first
   typedef struct packed {
      logic six_bit_primitive;
      logic ctrl_ind_enable;
      logic alt_protocol_select;
      logic monitor_enable;
   } gcicf_slot_cfg_t;

   // One entry of the command/indicate memory
   typedef struct packed {
      logic [1:0] repeat_count;
      logic [5:0] primitive_bits;
   } gcicf_ci_entry_t;

   // Processor access, one cycle strobes
   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic [1:0] byte_en;
      logic wr;
      logic rd;
   } gcicf_bus_req_t;

   typedef enum logic [1:0] {
      GCICF_SH_IDLE = 2'b00,
      GCICF_SH_SHIFT = 2'b01,
      GCICF_SH_UPDATE = 2'b10
   } gcicf_sh_state_t;

endpackage

// ==== core/gcicf_ci_mem.sv ====
/*
   Sixteen-entry command/indicate memory, one write port and one read
   port whose data come out of a register.
   Assumes the caller arbitrates the ports.
*/
`timescale 1ns/1ns
`default_nettype none
`include "gcicf_regs.svh"

module gcicf_ci_mem
   import gcicf_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic wr_en_in,
   input wire logic [3:0] wr_addr_in,
   input wire gcicf_ci_entry_t wr_data_in,
   input wire logic rd_en_in,
   input wire logic [3:0] rd_addr_in,
   output gcicf_ci_entry_t rd_data_out
);

   gcicf_ci_entry_t mem [16];

   // ----------------------------------------------------------------
   // Storage, cleared so no slot reads unknown before its first write
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         for (int i = 0; i < 16; i++)
         begin
            mem[i] <= '{repeat_count: 2'h0, primitive_bits: `GCICF_MEM_PRIM_RESET};
         end
      end
      else if (ce_in && wr_en_in)
      begin
         mem[wr_addr_in] <= wr_data_in;
      end
   end

   // Registered read, old data on a same-address write
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         rd_data_out <= '0;
      end
      else if (ce_in && rd_en_in)
      begin
         rd_data_out <= mem[rd_addr_in];
      end
   end

endmodule
`default_nettype wire

// ==== core/gcicf_ci_shifter.sv ====
/*
   Serialiser for one command/indicate primitive at a time, then a write
   back of the entry with its repeat count advanced, held at three.
   Assumes start_in only while busy_out is low.
*/
`timescale 1ns/1ns
`default_nettype none
`include "gcicf_regs.svh"

module gcicf_ci_shifter
   import gcicf_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic start_in,
   input wire logic [3:0] slot_in,
   input wire gcicf_ci_entry_t entry_in,
   input wire logic six_bit_in,
   output logic tx_bit_out,
   output logic tx_valid_out,
   output logic [3:0] tx_slot_out,
   output logic busy_out,
   output logic upd_valid_out,
   output gcicf_ci_entry_t upd_entry_out,
   input wire logic upd_ready_in
);

   gcicf_sh_state_t state;
   gcicf_ci_entry_t held;
   logic [2:0] left;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         state <= GCICF_SH_IDLE;
      end
      else if (ce_in)
      begin
         unique case (state)
            GCICF_SH_IDLE: if (start_in) state <= GCICF_SH_SHIFT;
            GCICF_SH_SHIFT: if (left == 3'h0) state <= GCICF_SH_UPDATE;
            GCICF_SH_UPDATE: if (upd_ready_in) state <= GCICF_SH_IDLE;
            default: state <= GCICF_SH_IDLE;
         endcase
      end
   end

   // Shift register, highest live bit first
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         held <= '0;
         left <= 3'h0;
         tx_bit_out <= 1'b1;
         tx_slot_out <= 4'h0;
      end
      else if (ce_in)
      begin
         if (state == GCICF_SH_IDLE && start_in)
         begin
            held <= entry_in;
            tx_slot_out <= slot_in;
            left <= six_bit_in ? `GCICF_FIRST_BIT_6 : `GCICF_FIRST_BIT_4;
            tx_bit_out <= six_bit_in ? entry_in.primitive_bits[5]
                                     : entry_in.primitive_bits[3];
         end
         else if (state == GCICF_SH_SHIFT && left != 3'h0)
         begin
            tx_bit_out <= held.primitive_bits[left - 3'h1];
            left <= left - 3'h1;
         end
      end
   end

   // Count saturates at three sends
   always_comb
   begin
      upd_entry_out = held;
      if (held.repeat_count != 2'h3)
      begin
         upd_entry_out.repeat_count = held.repeat_count + 2'h1;
      end
   end

   assign tx_valid_out = (state == GCICF_SH_SHIFT);
   assign upd_valid_out = (state == GCICF_SH_UPDATE);
   assign busy_out = (state != GCICF_SH_IDLE);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   first_bit_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      ce_in && state == GCICF_SH_IDLE && start_in
      |=> tx_valid_out && tx_bit_out == ($past(six_bit_in) ? $past(entry_in.primitive_bits[5])
                                                           : $past(entry_in.primitive_bits[3])))
      else $error("first primitive bit wrong");

   count_step_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      upd_valid_out |-> upd_entry_out.primitive_bits == held.primitive_bits
                        && upd_entry_out.repeat_count >= held.repeat_count
                        && upd_entry_out.repeat_count != 2'h0)
      else $error("repeat count not advanced");

endmodule
`default_nettype wire

// ==== core/gcicf_channel_port.sv ====
/*
   Channel configuration and command/indicate transmit port: four channel
   definition registers, the transmit command register, the primitive
   memory, per-slot monitor restart timers and the primitive serialiser.
   Assumes a 16-bit processor port with byte enables, single-cycle strobes,
   and a link side that asks for each slot's primitive with ci_req_in.
*/
`timescale 1ns/1ns
`default_nettype none
`include "gcicf_regs.svh"

module gcicf_channel_port
   import gcicf_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES = `GCICF_HOLD_CYCLES
)
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire gcicf_bus_req_t cpu_req_in,
   output logic [15:0] cpu_rdata_out,
   output logic cpu_ack_out,
   input wire logic ci_req_in,
   input wire logic [2:0] ci_req_chan_in,
   input wire logic ci_req_mux_in,
   output logic ci_tx_bit_out,
   output logic ci_tx_valid_out,
   output logic [2:0] ci_tx_chan_out,
   output logic ci_tx_mux_out,
   output logic ci_busy_out,
   output logic [15:0] mon_active_out,
   output logic [15:0] mon_alt_protocol_out,
   output logic [15:0] mon_restart_out,
   output logic [15:0] ci_active_out,
   output logic [15:0] ci_six_bit_out
);

   localparam logic [21:0] HOLD_LAST = 22'(HOLD_CYCLES - 1);

   // Slot number of a channel on a multiplex
   function automatic logic [3:0] slot_of(input logic [2:0] chan, input logic mux);
      slot_of = {chan, mux};
   endfunction

   logic [15:0] def_reg [4];
   gcicf_slot_cfg_t [15:0] slot_cfg;
   logic mux_sel;
   logic [2:0] chan_sel;
   logic read_sel;
   logic [5:0] pend_prim;
   gcicf_ci_entry_t readback;
   logic primitive_tx_command_wr_lo;
   logic primitive_tx_command_wr_hi;
   logic cpu_commit;
   logic cpu_fetch_req;
   logic cpu_fetch_pend;
   logic cpu_fetch_q;
   logic tx_take;
   logic tx_fetch_q;
   logic [3:0] tx_slot_q;
   gcicf_ci_entry_t commit_entry;
   gcicf_ci_entry_t mem_rd_data;
   gcicf_ci_entry_t upd_entry;
   logic upd_valid;
   logic sh_busy;
   logic [3:0] sh_slot;
   logic mem_wr_en;
   logic [3:0] mem_wr_addr;
   gcicf_ci_entry_t mem_wr_data;
   logic [3:0] mem_rd_addr;

   // ----------------------------------------------------------------
   // Channel definition registers
   // ----------------------------------------------------------------
   // Byte lanes written independently so an 8-bit host can set one channel
   generate
      for (genvar r = 0; r < 4; r++)
      begin : g_def
         localparam logic [7:0] DEF_ADDR = `GCICF_ADDR_DEF0 + 8'(2 * r);
         always_ff @(posedge clk_sys_in)
         begin
            if (rst_in)
            begin
               def_reg[r] <= `GCICF_DEF_RESET;
            end
            else if (ce_in && cpu_req_in.wr && cpu_req_in.addr == DEF_ADDR)
            begin
               if (cpu_req_in.byte_en[0]) def_reg[r][7:0] <= cpu_req_in.wdata[7:0];
               if (cpu_req_in.byte_en[1]) def_reg[r][15:8] <= cpu_req_in.wdata[15:8];
            end
         end
         // Low byte is channel 2r, high byte channel 2r+1
         assign slot_cfg[4 * r + 1:4 * r] = def_reg[r][7:0];
         assign slot_cfg[4 * r + 3:4 * r + 2] = def_reg[r][15:8];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Per-slot enables and monitor restart timers
   // ----------------------------------------------------------------
   generate
      for (genvar s = 0; s < 16; s++)
      begin : g_slot
         logic [21:0] idle_cnt;
         logic idle_done;
         assign mon_active_out[s] = slot_cfg[s].monitor_enable;
         assign mon_alt_protocol_out[s] = slot_cfg[s].monitor_enable
                                        & slot_cfg[s].alt_protocol_select;
         assign ci_active_out[s] = slot_cfg[s].ctrl_ind_enable;
         assign ci_six_bit_out[s] = slot_cfg[s].ctrl_ind_enable
                                  & slot_cfg[s].six_bit_primitive;

         // Time spent disabled; one restart pulse per disabled spell that lasts HOLD_CYCLES, none for a shorter one
         always_ff @(posedge clk_sys_in)
         begin
            if (rst_in)
            begin
               idle_cnt <= 22'h0;
               idle_done <= 1'b0;
               mon_restart_out[s] <= 1'b0;
            end
            else if (ce_in)
            begin
               mon_restart_out[s] <= 1'b0;
               if (slot_cfg[s].monitor_enable)
               begin
                  idle_cnt <= 22'h0;
                  idle_done <= 1'b0;
               end
               else if (!idle_done)
               begin
                  if (idle_cnt == HOLD_LAST)
                  begin
                     idle_done <= 1'b1;
                     mon_restart_out[s] <= 1'b1;
                  end
                  else
                  begin
                     idle_cnt <= idle_cnt + 22'h1;
                  end
               end
            end
         end

         mon_restart_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
            ce_in && !idle_done && !slot_cfg[s].monitor_enable && idle_cnt == HOLD_LAST
            |=> mon_restart_out[s] ##1 !mon_restart_out[s] || !ce_in)
            else $error("monitor restart pulse missing");
      end
   endgenerate

   // ----------------------------------------------------------------
   // Transmit command register
   // ----------------------------------------------------------------
   assign primitive_tx_command_wr_lo = cpu_req_in.wr && cpu_req_in.byte_en[0]
                     && cpu_req_in.addr == `GCICF_ADDR_PRIMITIVE_TX_COMMAND;
   assign primitive_tx_command_wr_hi = cpu_req_in.wr && cpu_req_in.byte_en[1]
                     && cpu_req_in.addr == `GCICF_ADDR_PRIMITIVE_TX_COMMAND;
   // Only the upper byte launches a command; the low byte just waits
   assign cpu_commit = ce_in && primitive_tx_command_wr_hi && !cpu_req_in.wdata[`GCICF_PRIMITIVE_TX_COMMAND_READ_BIT];
   assign cpu_fetch_req = primitive_tx_command_wr_hi && cpu_req_in.wdata[`GCICF_PRIMITIVE_TX_COMMAND_READ_BIT];
   assign commit_entry.repeat_count = 2'h0;
   assign commit_entry.primitive_bits = primitive_tx_command_wr_lo
      ? cpu_req_in.wdata[`GCICF_PRIMITIVE_TX_COMMAND_PRIM_HI:`GCICF_PRIMITIVE_TX_COMMAND_PRIM_LO] : pend_prim;

   // Address, direction and pending primitive fields
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         mux_sel <= 1'b0;
         chan_sel <= 3'h0;
         read_sel <= 1'b0;
         pend_prim <= `GCICF_PRIM_RESET;
      end
      else if (ce_in)
      begin
         if (primitive_tx_command_wr_lo)
         begin
            pend_prim <= cpu_req_in.wdata[`GCICF_PRIMITIVE_TX_COMMAND_PRIM_HI:`GCICF_PRIMITIVE_TX_COMMAND_PRIM_LO];
         end
         if (primitive_tx_command_wr_hi)
         begin
            mux_sel <= cpu_req_in.wdata[`GCICF_PRIMITIVE_TX_COMMAND_MUX_BIT];
            chan_sel <= cpu_req_in.wdata[`GCICF_PRIMITIVE_TX_COMMAND_CA_HI:`GCICF_PRIMITIVE_TX_COMMAND_CA_LO];
            read_sel <= cpu_req_in.wdata[`GCICF_PRIMITIVE_TX_COMMAND_READ_BIT];
         end
      end
   end

   // Read-back of the addressed entry; a fetch waits while the link reads
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         readback <= '{repeat_count: `GCICF_COUNT_RESET, primitive_bits: `GCICF_PRIM_RESET};
         cpu_fetch_pend <= 1'b0;
         cpu_fetch_q <= 1'b0;
      end
      else if (ce_in)
      begin
         cpu_fetch_q <= cpu_fetch_pend && !tx_take;
         if (cpu_fetch_req)
         begin
            cpu_fetch_pend <= 1'b1;
         end
         else if (!tx_take)
         begin
            cpu_fetch_pend <= 1'b0;
         end
         if (cpu_commit)
         begin
            readback <= commit_entry;
         end
         else if (cpu_fetch_q)
         begin
            readback <= mem_rd_data;
         end
      end
   end

   // ----------------------------------------------------------------
   // Processor reads, answered one cycle after the strobe
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         cpu_rdata_out <= 16'h0000;
         cpu_ack_out <= 1'b0;
      end
      else if (ce_in)
      begin
         cpu_ack_out <= cpu_req_in.rd || cpu_req_in.wr;
         if (cpu_req_in.rd)
         begin
            unique case (cpu_req_in.addr)
               `GCICF_ADDR_DEF0: cpu_rdata_out <= def_reg[0];
               `GCICF_ADDR_DEF1: cpu_rdata_out <= def_reg[1];
               `GCICF_ADDR_DEF2: cpu_rdata_out <= def_reg[2];
               `GCICF_ADDR_DEF3: cpu_rdata_out <= def_reg[3];
               `GCICF_ADDR_PRIMITIVE_TX_COMMAND: cpu_rdata_out <= {1'b0, mux_sel, chan_sel, read_sel, 2'b00,
                                                   readback};
               default: cpu_rdata_out <= 16'h0000;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Link side: fetch then serialise the slot's primitive
   // ----------------------------------------------------------------
   // Requests for disabled slots or while busy are dropped
   assign tx_take = ci_req_in && !sh_busy && !tx_fetch_q
                  && slot_cfg[slot_of(ci_req_chan_in, ci_req_mux_in)].ctrl_ind_enable;

   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         tx_fetch_q <= 1'b0;
         tx_slot_q <= 4'h0;
      end
      else if (ce_in)
      begin
         tx_fetch_q <= tx_take;
         if (tx_take)
         begin
            tx_slot_q <= slot_of(ci_req_chan_in, ci_req_mux_in);
         end
      end
   end

   // Processor write wins the port; the count update simply waits
   assign mem_wr_en = cpu_commit || upd_valid;
   assign mem_wr_addr = cpu_commit ? slot_of(cpu_req_in.wdata[`GCICF_PRIMITIVE_TX_COMMAND_CA_HI:`GCICF_PRIMITIVE_TX_COMMAND_CA_LO],
                                             cpu_req_in.wdata[`GCICF_PRIMITIVE_TX_COMMAND_MUX_BIT]) : sh_slot;
   assign mem_wr_data = cpu_commit ? commit_entry : upd_entry;
   assign mem_rd_addr = tx_take ? slot_of(ci_req_chan_in, ci_req_mux_in)
                                : slot_of(chan_sel, mux_sel);

   gcicf_ci_mem u_mem (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .wr_en_in(mem_wr_en),
      .wr_addr_in(mem_wr_addr),
      .wr_data_in(mem_wr_data),
      .rd_en_in(tx_take || cpu_fetch_pend),
      .rd_addr_in(mem_rd_addr),
      .rd_data_out(mem_rd_data)
   );

   gcicf_ci_shifter u_shift (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .start_in(tx_fetch_q),
      .slot_in(tx_slot_q),
      .entry_in(mem_rd_data),
      .six_bit_in(slot_cfg[tx_slot_q].six_bit_primitive),
      .tx_bit_out(ci_tx_bit_out),
      .tx_valid_out(ci_tx_valid_out),
      .tx_slot_out(sh_slot),
      .busy_out(sh_busy),
      .upd_valid_out(upd_valid),
      .upd_entry_out(upd_entry),
      .upd_ready_in(!cpu_commit)
   );

   assign ci_tx_chan_out = sh_slot[3:1];
   assign ci_tx_mux_out = sh_slot[0];
   assign ci_busy_out = sh_busy || tx_fetch_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   def_write_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      ce_in && cpu_req_in.wr && cpu_req_in.addr == `GCICF_ADDR_DEF1 && cpu_req_in.byte_en[1]
      |=> slot_cfg[7] == $past(cpu_req_in.wdata[15:12]))
      else $error("definition nibble not stored");

   mon_alt_gate_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (mon_alt_protocol_out & ~mon_active_out) == 16'h0000)
      else $error("alternative protocol on disabled monitor");

   low_byte_hold_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      ce_in && primitive_tx_command_wr_lo && !primitive_tx_command_wr_hi |-> mem_wr_en == upd_valid)
      else $error("primitive taken without upper byte");

   commit_store_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      cpu_commit |=> readback.repeat_count == 2'h0
                     && readback.primitive_bits == $past(commit_entry.primitive_bits))
      else $error("new primitive not captured");

   read_no_write_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      ce_in && cpu_fetch_req |-> !cpu_commit ##1 cpu_fetch_pend)
      else $error("read command treated as write");

   tx_enabled_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      ce_in && tx_take |=> tx_fetch_q && slot_cfg[tx_slot_q].ctrl_ind_enable
                           || $past(slot_cfg) != slot_cfg)
      else $error("disabled channel served");

   tx_length_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      ce_in && tx_fetch_q && !slot_cfg[tx_slot_q].six_bit_primitive
      ##1 ce_in [*4] |=> !ci_tx_valid_out)
      else $error("four-bit primitive too long");

endmodule
`default_nettype wire

// ==== tb/gcicf_link_model.sv ====
/* Link-side model: asks for one slot's primitive and collects its bits.
   Assumes the bench launches one request at a time with go_in. */
`timescale 1ns/1ns
`default_nettype none
module gcicf_link_model
(
   input wire logic clk_sys_in,
   input wire logic go_in,
   input wire logic [3:0] slot_in,
   output logic ci_req_out,
   output logic [3:0] slot_out,
   input wire logic tx_bit_in,
   input wire logic tx_valid_in,
   output logic [15:0] word_out
);
   // ------
   // Request and capture
   // ------
   // Upper byte counts bits, so a missing or extra bit shows up
   always @(posedge clk_sys_in)
   begin
      ci_req_out <= go_in;
      if (go_in)
      begin
         slot_out <= slot_in;
         word_out <= 16'h0000;
      end
      else
      begin
         slot_out <= ~slot_out; // Released lines do not keep the old slot
         if (tx_valid_in)
            word_out <= {word_out[15:8] + 8'h01, word_out[6:0], tx_bit_in};
      end
   end
endmodule
`default_nettype wire

// ==== tb/gcicf_channel_port_test.sv ====
/* Bench for the channel port: register table, sends and read-back.
   Assumes the link model beside it and a 50 ns clock. */
`timescale 1ns/1ns
`default_nettype none
module gcicf_channel_port_test
   import gcicf_pkg::*;
;
   logic clk_sys_in = 1'b0, rst_in = 1'b1, go = 1'b0, ack, req_w, bit_w, valid_w;
   logic ce = 1'b1, busy;
   logic [3:0] slot = 4'h0, lslot, tslot;
   gcicf_bus_req_t req = '0;
   logic [15:0] rdata, mon_act, mon_alt, mon_rst, ci_act, ci_six, word, q;
   int n_errors = 0, checks = 0, k, hit, at;
   // Address, value written, value read back
   logic [39:0] rows [9] = '{40'h22FFFFFFFF, 40'h2412341234, 40'h2684218421, 40'h28FFFFFFFF,
      40'h30FFFF0000, 40'h2400000000, 40'h2600000000, 40'h2800000000, 40'h22C4A3C4A3};
   gcicf_channel_port #(.HOLD_CYCLES(8)) i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .ce_in(ce), .cpu_req_in(req), .cpu_rdata_out(rdata), .cpu_ack_out(ack),
      .ci_req_in(req_w), .ci_req_chan_in(lslot[3:1]), .ci_req_mux_in(lslot[0]),
      .ci_tx_bit_out(bit_w), .ci_tx_valid_out(valid_w), .ci_tx_chan_out(tslot[3:1]),
      .ci_tx_mux_out(tslot[0]), .ci_busy_out(busy), .mon_active_out(mon_act),
      .mon_alt_protocol_out(mon_alt),
      .mon_restart_out(mon_rst), .ci_active_out(ci_act), .ci_six_bit_out(ci_six));
   gcicf_link_model i_link (.clk_sys_in(clk_sys_in), .go_in(go), .slot_in(slot),
      .ci_req_out(req_w), .slot_out(lslot), .tx_bit_in(bit_w), .tx_valid_in(valid_w),
      .word_out(word));
   // ------
   // Tasks
   // ------
   task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Strobe lasts one cycle; address and data stay put until the ack edge
   task bus(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be, input logic w);
      @(posedge clk_sys_in);
      req <= '{a, d, be, w, ~w};
      @(posedge clk_sys_in);
      req.wr <= 1'b0;
      req.rd <= 1'b0;
      #1 q = rdata;
      chk("ack", 16'h0001, {15'h0000, ack});
   endtask
   task send(input logic [3:0] s, input logic [15:0] exp);
      @(posedge clk_sys_in);
      go <= 1'b1;
      slot <= s;
      @(posedge clk_sys_in);
      go <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      #1 chk("busy", {15'h0000, exp != 16'h0000}, {15'h0000, busy});
      if (exp != 16'h0000) chk("slot", {12'h000, s}, {12'h000, tslot});
      repeat (9) @(posedge clk_sys_in);
      #1 chk("word", exp, word);
      chk("idle", 16'h0000, {15'h0000, busy});
   endtask
   task finish_test;
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ------
   // Sequence
   // ------
   initial
      forever #25 clk_sys_in = ~clk_sys_in;
   initial
   begin
      repeat (2000) @(posedge clk_sys_in);
      n_errors++;
      finish_test;
   end
   initial
   begin
      repeat (8) @(posedge clk_sys_in);
      rst_in <= 1'b0; // Enables are low for only four cycles before the table writes DEF0, short of the hold
      bus(8'h2A, 16'h0000, 2'b11, 1'b0);
      chk("primitive_tx_command", 16'h00FF, q);
      $display("reset test done");
      foreach (rows[i])
      begin
         bus(rows[i][39:32], rows[i][31:16], 2'b11, 1'b1);
         bus(rows[i][39:32], 16'h0000, 2'b11, 1'b0);
         chk("reg", rows[i][15:0], q);
      end
      chk("mon", 16'h0001, mon_act);
      chk("alt", 16'h0001, mon_alt);
      chk("ci", 16'h000C, ci_act);
      chk("six", 16'h0008, ci_six);
      $display("table test done");
      // Low byte alone must not launch; the old primitive still goes out
      bus(8'h2A, 16'h0015, 2'b01, 1'b1);
      send(4'h2, 16'h040F);
      bus(8'h2A, 16'h0800, 2'b10, 1'b1);
      send(4'h2, 16'h0405);
      bus(8'h2A, 16'h4825, 2'b11, 1'b1);
      send(4'h3, 16'h0625);
      send(4'h3, 16'h0625);
      send(4'h1, 16'h0000);
      bus(8'h2A, 16'h4C00, 2'b10, 1'b1);
      repeat (4) @(posedge clk_sys_in);
      bus(8'h2A, 16'h0000, 2'b11, 1'b0);
      chk("readback", 16'h4CA5, q);
      // Two more sends must stop the count at three, not wrap it
      send(4'h3, 16'h0625);
      send(4'h3, 16'h0625);
      bus(8'h2A, 16'h4C00, 2'b10, 1'b1);
      repeat (4) @(posedge clk_sys_in);
      bus(8'h2A, 16'h0000, 2'b11, 1'b0);
      chk("saturate", 16'h4CE5, q);
      $display("send test done");
      // Enable stays cleared through the whole hold
      bus(8'h22, 16'hC4A2, 2'b11, 1'b1);
      hit = 0;
      at = 0;
      // Three frozen cycles in the middle push the single pulse three later
      for (k = 0; k < 14; k++)
      begin
         @(posedge clk_sys_in);
         if (k == 2) ce <= 1'b0;
         if (k == 5) ce <= 1'b1;
         #1;
         if (mon_rst[0] === 1'b1)
         begin
            hit++;
            at = k;
         end
      end
      chk("restart", 16'h010A, {8'(hit), 8'(at)});
      chk("mon", 16'h0000, mon_act);
      $display("restart test done");
      // Reset in mid-run must undo the command register and definitions
      @(posedge clk_sys_in);
      rst_in <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      bus(8'h2A, 16'h0000, 2'b11, 1'b0);
      chk("primitive_tx_command", 16'h00FF, q);
      bus(8'h22, 16'h0000, 2'b11, 1'b0);
      chk("def", 16'h0000, q);
      $display("second reset test done");
      finish_test;
   end
endmodule
`default_nettype wire
